// ### bsr_pkg.sv
/*
 * Shared constants for the bridge status and port timing readback block:
 * command and pointer codes, status bit positions, readback table layout,
 * bus engine states.
 * Assumes nothing of its surroundings; compiled before every other file.
 */
package bsr_pkg;

	// Command codes that the block decodes itself
	localparam logic [7:0] CMD_DEV_RESET = 8'hf0;
	localparam logic [7:0] CMD_SET_PTR = 8'he1;
	localparam logic [7:0] CMD_WRITE_CFG = 8'hd2;

	// Read pointer codes
	localparam logic [7:0] PTR_CFG = 8'hc3;
	localparam logic [7:0] PTR_STATUS = 8'hf0;
	localparam logic [7:0] PTR_RDATA = 8'he1;
	localparam logic [7:0] PTR_PORT = 8'hb4;

	// Status bit positions, bit 0 upward
	localparam int ST_BUSY = 0;
	localparam int ST_PRES = 1;
	localparam int ST_SHORT = 2;
	localparam int ST_LEVEL = 3;
	localparam int ST_RST = 4;
	localparam int ST_SBR = 5;
	localparam int ST_TSB = 6;
	localparam int ST_DIR = 7;

	// Status after power-on or device reset: only the reset flag set
	localparam logic [7:0] STATUS_RESET = 8'h10;

	// Port timing readback table: eight 4-bit codes
	localparam int PT_ENTRIES = 8;
	localparam logic [2:0] PT_FIRST = 3'h0;
	localparam logic [2:0] PT_LAST = 3'h7;
	localparam logic [2:0] PT_REC0_IDX = 3'h6;
	localparam logic [2:0] PT_PULLUP_IDX = 3'h7;
	localparam logic [2:0] PT_NUM_REC0 = 3'h3;
	localparam logic [2:0] PT_NUM_PULLUP = 3'h4;
	localparam logic [31:0] PT_DEFAULTS = 32'h6666_6666;

	// Field positions of the adjust-port parameter byte
	localparam int ADJ_NUM_LSB = 5;
	localparam int ADJ_OD_BIT = 4;

	// Bits per byte on the host bus
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// Which engine sample a bit event carries
	typedef enum logic [1:0] {
		BIT_FIRST = 2'h0,
		BIT_SECOND = 2'h1,
		BIT_DIR = 2'h2
	} bsr_bit_type;

	// Host bus byte engine states, one-hot
	typedef enum logic [9:0] {
		S_IDLE = 10'h001,
		S_ADDR = 10'h002,
		S_ADDR_ACK = 10'h004,
		S_CMD = 10'h008,
		S_CMD_ACK = 10'h010,
		S_PARAM = 10'h020,
		S_PARAM_ACK = 10'h040,
		S_RD = 10'h080,
		S_RD_ACK = 10'h100,
		S_IGNORE = 10'h200
	} bsr_state_type;

endpackage

// ### bsr_pts_if.sv
/*
 * Interface between the main block and the port timing store.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface bsr_pts_if;
	logic we; // Write one entry
	logic [2:0] waddr; // Entry written
	logic [3:0] wdata; // Code written
	logic restore; // Reload every entry with its default
	logic [2:0] raddr; // Entry read
	logic [3:0] rdata; // Registered read data

	modport store (input we, waddr, wdata, restore, raddr, output rdata);
	modport user (output we, waddr, wdata, restore, raddr, input rdata);
endinterface

// ### bsr_port_store.sv
/*
 * Port timing store: eight 4-bit parameter codes with registered read.
 * Assumes writes and restores come from the main block on the same clock.
 */
`timescale 1ns/1ps
module bsr_port_store
	import bsr_pkg::*;
#(
	parameter logic [31:0] DEFAULTS = PT_DEFAULTS
) (
	input wire logic clock,
	input wire logic resetn,
	bsr_pts_if.store pts
);

	logic [3:0] mem [PT_ENTRIES]; // Stored codes
	logic [3:0] next_mem [PT_ENTRIES];
	logic [3:0] rdata_q; // Read register
	logic [3:0] next_rdata;

	// One storage cell per entry
	genvar i;
	generate
		for (i = 0; i < PT_ENTRIES; i++) begin : g_entry
			// Restore beats a write so a device reset always lands on defaults
			always_comb begin
				next_mem[i] = mem[i];
				if (pts.restore) begin
					next_mem[i] = DEFAULTS[i*4 +: 4];
				end else if (pts.we && pts.waddr == 3'(i)) begin
					next_mem[i] = pts.wdata;
				end
			end

			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					mem[i] <= DEFAULTS[i*4 +: 4];
				end else begin
					mem[i] <= next_mem[i];
				end
			end
		end
	endgenerate

	// Read data always comes out of a register
	always_comb begin
		next_rdata = mem[pts.raddr];
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 4'h0;
		end else begin
			rdata_q <= next_rdata;
		end
	end

	assign pts.rdata = rdata_q;

endmodule

// ### bsr_status_port.sv
/*
 * Status and port timing readback of a host-bus to single-wire bridge,
 * with the host bus slave that moves the read pointer.
 * Assumes the line engine runs on this clock and reports its samples as
 * one-cycle pulses; the bus pins and the line level come from outside.
 */
// How it works
// - Status byte: dir, tsb, sbr, rst, level, short, presence, busy
// - Host reads status, config, data or port byte, as the pointer selects
// - Line commands and device reset point at status
// - Status changes only on commands, engine events and level samples
// - Busy is high for whole line command
// - Line reset updates presence from its sample
// - Line reset sets short on low sample
// - Short flag forces presence flag low
// - Level sampled at read-address ack, pointer on status
// - Reset flag set by resets, cleared by config write
// - Single bit result takes first sampled bit
// - Second triplet bit captured only by triplet
// - Direction captured only by triplet third bit
// - Port readback: code low, upper nibble zero
// - Adjust port points at port readback
// - Port readback walks the fixed parameter order
// - Port readback wraps after the pullup entry
// - Bad code or parameter is not acknowledged
// - Each command moves the pointer itself
// - Device reset sets rst, clears other flags
// - Pointer codes select config, status, data, port
`timescale 1ns/1ps
module bsr_status_port
	import bsr_pkg::*;
#(
	parameter logic [6:0] BUS_ADDR = 7'h10, // Arbitrary slave address
	parameter logic [7:0] CMD_ADJUST_PORT = 8'h01, // Arbitrary code
	parameter logic [7:0] CMD_LINE_RESET = 8'h02, // Arbitrary code
	parameter logic [7:0] CMD_SINGLE_BIT = 8'h03, // Arbitrary code
	parameter logic [7:0] CMD_WRITE_BYTE = 8'h04, // Arbitrary code
	parameter logic [7:0] CMD_READ_BYTE = 8'h05, // Arbitrary code
	parameter logic [7:0] CMD_TRIPLET = 8'h06 // Arbitrary code
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic line_in,
	input wire logic eng_done,
	input wire logic eng_rst_evt,
	input wire logic eng_presence,
	input wire logic eng_short,
	input wire logic eng_bit_evt,
	input wire bsr_bit_type eng_bit_sel,
	input wire logic eng_bit_val,
	input wire logic [7:0] cfg_value,
	input wire logic [7:0] read_data_value,
	output logic line_cmd_go,
	output logic [7:0] line_cmd_code,
	output logic [7:0] line_cmd_param,
	output logic line_abort,
	output logic cfg_wr,
	output logic [7:0] cfg_byte,
	output logic [7:0] line_status,
	output logic [7:0] read_pointer
);

	bsr_pts_if pts ();

	bsr_port_store u_store (
		.clock(clock),
		.resetn(resetn),
		.pts(pts)
	);

	// Pin synchronisers; stage 0 feeds only stage 1
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic [1:0] line_sync;
	logic scl_d; // Delayed copy for edge finding
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic start_c; // Data falls while clock high
	logic stop_c; // Data rises while clock high

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			line_sync <= 2'h3;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			line_sync <= {line_sync[0], line_in};
			scl_d <= scl_sync[1];
			sda_d <= sda_sync[1];
		end
	end

	assign scl_rise = scl_sync[1] && !scl_d;
	assign scl_fall = !scl_sync[1] && scl_d;
	assign start_c = scl_sync[1] && scl_d && !sda_sync[1] && sda_d;
	assign stop_c = scl_sync[1] && scl_d && sda_sync[1] && !sda_d;

	// Bus engine state
	bsr_state_type state, next_state;
	logic [3:0] bitcnt, next_bitcnt; // Bits of current byte
	logic [7:0] shreg, next_shreg; // Received byte; bit 0 keeps host ack
	logic [7:0] tx, next_tx; // Byte being sent
	logic [7:0] cmd_q, next_cmd; // Accepted command code
	logic rw, next_rw; // Read transfer
	logic oe_q, next_oe; // Pulls data low
	logic exec, next_exec; // Command takes effect
	logic ll_sample, next_ll_sample; // Read-address ack clock rose
	logic port_adv, next_port_adv; // Port byte loaded for sending
	logic [7:0] rd_byte; // Selected register

	// Status group state
	logic [7:0] next_status;
	logic [7:0] next_ptr;
	logic [2:0] port_idx, next_idx; // Next port entry to send
	logic next_go, next_abort, next_cfg_wr;
	logic [7:0] next_code, next_param, next_cfg_byte;
	logic pts_we, next_pts_we, pts_restore, next_pts_restore;
	logic [2:0] pts_waddr, next_pts_waddr;
	logic [3:0] pts_wdata, next_pts_wdata;

	function automatic logic is_line_cmd(input logic [7:0] c);
		return c == CMD_LINE_RESET || c == CMD_SINGLE_BIT || c == CMD_WRITE_BYTE
			|| c == CMD_READ_BYTE || c == CMD_TRIPLET;
	endfunction

	function automatic logic has_param(input logic [7:0] c);
		return c == CMD_SET_PTR || c == CMD_WRITE_CFG || c == CMD_ADJUST_PORT
			|| c == CMD_SINGLE_BIT || c == CMD_WRITE_BYTE || c == CMD_TRIPLET;
	endfunction

	// Config, adjust-port and line commands wait for the line; device reset and set-pointer run any time
	function automatic logic cmd_ok(input logic [7:0] c, input logic busy);
		if (c == CMD_DEV_RESET || c == CMD_SET_PTR) begin
			return 1'b1;
		end else if (c == CMD_WRITE_CFG || c == CMD_ADJUST_PORT || is_line_cmd(c)) begin
			return !busy;
		end
		return 1'b0;
	endfunction

	function automatic logic param_ok(input logic [7:0] c, input logic [7:0] p);
		if (c == CMD_SET_PTR) begin
			return p == PTR_CFG || p == PTR_STATUS || p == PTR_RDATA || p == PTR_PORT;
		end else if (c == CMD_WRITE_CFG) begin
			return p[7:4] == ~p[3:0];
		end else if (c == CMD_ADJUST_PORT) begin
			return p[7:ADJ_NUM_LSB] <= PT_NUM_PULLUP;
		end
		return 1'b1;
	endfunction

	// Adjust-port parameter number and speed to table entry
	function automatic logic [2:0] adj_entry(input logic [7:0] p);
		if (p[7:ADJ_NUM_LSB] == PT_NUM_REC0) begin
			return PT_REC0_IDX;
		end else if (p[7:ADJ_NUM_LSB] == PT_NUM_PULLUP) begin
			return PT_PULLUP_IDX;
		end
		return {p[ADJ_NUM_LSB+1:ADJ_NUM_LSB], p[ADJ_OD_BIT]};
	endfunction

	// Read mux; a read touches no flag but the level sampled at its address ack
	always_comb begin
		if (read_pointer == PTR_STATUS) begin
			rd_byte = line_status;
		end else if (read_pointer == PTR_PORT) begin
			rd_byte = {4'h0, pts.rdata};
		end else if (read_pointer == PTR_CFG) begin
			rd_byte = {4'h0, cfg_value[3:0]};
		end else begin
			rd_byte = read_data_value;
		end
	end

	// Bus engine: bits in on rising clock, out and ack on falling clock
	always_comb begin
		next_state = state;
		next_bitcnt = bitcnt;
		next_shreg = shreg;
		next_tx = tx;
		next_cmd = cmd_q;
		next_rw = rw;
		next_oe = oe_q;
		next_exec = 1'b0;
		next_ll_sample = 1'b0;
		next_port_adv = 1'b0;
		if (start_c) begin
			next_state = S_ADDR;
			next_bitcnt = 4'h0;
			next_oe = 1'b0;
		end else if (stop_c) begin
			next_state = S_IDLE;
			next_oe = 1'b0;
		end else begin
			case (state)
				S_ADDR, S_CMD, S_PARAM: begin
					if (scl_rise && bitcnt != BITS_PER_BYTE) begin
						next_shreg = {shreg[6:0], sda_sync[1]};
						next_bitcnt = 4'(bitcnt + 4'h1);
					end else if (scl_fall && bitcnt == BITS_PER_BYTE) begin
						next_bitcnt = 4'h0;
						// Bad address, code or parameter gets no ack
						next_state = S_IGNORE;
						if (state == S_ADDR && shreg[7:1] == BUS_ADDR) begin
							next_state = S_ADDR_ACK;
							next_rw = shreg[0];
							next_oe = 1'b1;
						end else if (state == S_CMD && cmd_ok(shreg, line_status[ST_BUSY])) begin
							next_state = S_CMD_ACK;
							next_cmd = shreg;
							next_oe = 1'b1;
						end else if (state == S_PARAM && param_ok(cmd_q, shreg)) begin
							next_state = S_PARAM_ACK;
							next_oe = 1'b1;
						end
					end
				end
				S_ADDR_ACK: begin
					if (scl_rise) begin
						next_ll_sample = rw;
					end else if (scl_fall && rw) begin
						next_state = S_RD;
						next_tx = rd_byte;
						next_oe = !rd_byte[7];
						next_bitcnt = 4'h1;
						next_port_adv = read_pointer == PTR_PORT;
					end else if (scl_fall) begin
						next_state = S_CMD;
						next_oe = 1'b0;
					end
				end
				S_CMD_ACK, S_PARAM_ACK: begin
					if (scl_rise) begin
						// Takes effect on the rising clock of the ack bit
						next_exec = state == S_PARAM_ACK || !has_param(cmd_q);
					end else if (scl_fall) begin
						next_oe = 1'b0;
						next_state = (state == S_CMD_ACK && has_param(cmd_q)) ? S_PARAM : S_IGNORE;
					end
				end
				S_RD: begin
					if (scl_fall && bitcnt == BITS_PER_BYTE) begin
						next_oe = 1'b0;
						next_state = S_RD_ACK;
					end else if (scl_fall) begin
						next_tx = {tx[6:0], 1'b0};
						next_oe = !tx[6];
						next_bitcnt = 4'(bitcnt + 4'h1);
					end
				end
				S_RD_ACK: begin
					if (scl_rise) begin
						next_shreg = {7'h00, sda_sync[1]};
					end else if (scl_fall && shreg[0]) begin
						next_state = S_IGNORE;
					end else if (scl_fall) begin
						// Host acked: stream the next byte
						next_state = S_RD;
						next_tx = rd_byte;
						next_oe = !rd_byte[7];
						next_bitcnt = 4'h1;
						next_port_adv = read_pointer == PTR_PORT;
					end
				end
				default: begin
					// Idle and ignore wait for a start
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= S_IDLE;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			tx <= 8'h00;
			cmd_q <= 8'h00;
			rw <= 1'b0;
			oe_q <= 1'b0;
			exec <= 1'b0;
			ll_sample <= 1'b0;
			port_adv <= 1'b0;
		end else begin
			state <= next_state;
			bitcnt <= next_bitcnt;
			shreg <= next_shreg;
			tx <= next_tx;
			cmd_q <= next_cmd;
			rw <= next_rw;
			oe_q <= next_oe;
			exec <= next_exec;
			ll_sample <= next_ll_sample;
			port_adv <= next_port_adv;
		end
	end

	// Status, pointer and command outputs; flags move only on events
	always_comb begin
		next_status = line_status;
		next_ptr = read_pointer;
		next_idx = port_idx;
		next_go = 1'b0;
		next_abort = 1'b0;
		next_cfg_wr = 1'b0;
		next_code = line_cmd_code;
		next_param = line_cmd_param;
		next_cfg_byte = cfg_byte;
		next_pts_we = 1'b0;
		next_pts_restore = 1'b0;
		next_pts_waddr = pts_waddr;
		next_pts_wdata = pts_wdata;
		if (eng_done) begin
			next_status[ST_BUSY] = 1'b0;
		end
		if (eng_rst_evt) begin
			next_status[ST_SHORT] = eng_short;
			next_status[ST_PRES] = eng_presence && !eng_short;
		end
		if (eng_bit_evt) begin
			case (eng_bit_sel)
				BIT_FIRST: next_status[ST_SBR] = eng_bit_val;
				BIT_SECOND: next_status[ST_TSB] = eng_bit_val;
				BIT_DIR: next_status[ST_DIR] = eng_bit_val;
				default: begin
					// Unused select moves no flag; other events of this cycle still land
				end
			endcase
		end
		if (ll_sample && read_pointer == PTR_STATUS) begin
			next_status[ST_LEVEL] = line_sync[1];
		end
		if (port_adv) begin
			next_idx = (port_idx == PT_LAST) ? PT_FIRST : 3'(port_idx + 3'h1);
		end
		// Command effects come last so they win over engine events
		if (exec) begin
			if (cmd_q == CMD_DEV_RESET) begin
				next_status = STATUS_RESET;
				next_ptr = PTR_STATUS;
				next_abort = 1'b1;
				next_pts_restore = 1'b1;
				next_idx = PT_FIRST;
			end else if (cmd_q == CMD_SET_PTR) begin
				next_ptr = shreg;
			end else if (cmd_q == CMD_WRITE_CFG) begin
				next_status[ST_RST] = 1'b0;
				next_ptr = PTR_CFG;
				next_cfg_wr = 1'b1;
				next_cfg_byte = shreg;
			end else if (cmd_q == CMD_ADJUST_PORT) begin
				next_ptr = PTR_PORT;
				next_idx = PT_FIRST;
				next_pts_we = 1'b1;
				next_pts_waddr = adj_entry(shreg);
				next_pts_wdata = shreg[3:0];
			end else begin
				next_status[ST_BUSY] = 1'b1;
				next_ptr = PTR_STATUS;
				next_go = 1'b1;
				next_code = cmd_q;
				next_param = shreg;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			line_status <= STATUS_RESET;
			read_pointer <= PTR_STATUS;
			port_idx <= PT_FIRST;
			line_cmd_go <= 1'b0;
			line_abort <= 1'b0;
			cfg_wr <= 1'b0;
			line_cmd_code <= 8'h00;
			line_cmd_param <= 8'h00;
			cfg_byte <= 8'h00;
			pts_we <= 1'b0;
			pts_restore <= 1'b0;
			pts_waddr <= 3'h0;
			pts_wdata <= 4'h0;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			line_status <= next_status;
			read_pointer <= next_ptr;
			port_idx <= next_idx;
			line_cmd_go <= next_go;
			line_abort <= next_abort;
			cfg_wr <= next_cfg_wr;
			line_cmd_code <= next_code;
			line_cmd_param <= next_param;
			cfg_byte <= next_cfg_byte;
			pts_we <= next_pts_we;
			pts_restore <= next_pts_restore;
			pts_waddr <= next_pts_waddr;
			pts_wdata <= next_pts_wdata;
			sda_oe <= next_oe;
			sda_out <= 1'b0; // Open drain: only ever pulls low
		end
	end

	assign pts.we = pts_we;
	assign pts.waddr = pts_waddr;
	assign pts.wdata = pts_wdata;
	assign pts.restore = pts_restore;
	assign pts.raddr = port_idx;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	chk_short_kills_pres: assert property (line_status[ST_SHORT] |-> !line_status[ST_PRES])
		else $error("presence set while short set");
	chk_go_sets_busy: assert property (line_cmd_go |-> line_status[ST_BUSY])
		else $error("line command started without busy");
	chk_go_ptr_status: assert property (line_cmd_go |-> read_pointer == PTR_STATUS)
		else $error("line command left pointer off status");
	chk_busy_done_clear: assert property (eng_done && !exec |=> !line_status[ST_BUSY])
		else $error("busy not cleared at completion");
	chk_dev_reset_flags: assert property (exec && cmd_q == CMD_DEV_RESET |=>
		line_status == STATUS_RESET && read_pointer == PTR_STATUS ##1 line_status[ST_RST])
		else $error("device reset left wrong status");
	chk_adjust_ptr_port: assert property (exec && cmd_q == CMD_ADJUST_PORT |=>
		read_pointer == PTR_PORT && port_idx == PT_FIRST)
		else $error("adjust port left pointer wrong");
	chk_port_upper_zero: assert property (port_adv |-> tx[7:4] == 4'h0)
		else $error("port byte upper nibble not zero");
	chk_port_idx_wrap: assert property (port_adv && !exec && port_idx == PT_LAST |=>
		port_idx == PT_FIRST)
		else $error("port readback did not wrap");
	chk_status_hold: assert property (!exec && !eng_done && !eng_rst_evt && !eng_bit_evt
		&& !ll_sample |=> $stable(line_status))
		else $error("status changed without cause");
	chk_pres_update: assert property (eng_rst_evt && !exec |=>
		line_status[ST_PRES] == ($past(eng_presence) && !$past(eng_short)))
		else $error("presence not updated by line reset");
	chk_level_sample: assert property (ll_sample && read_pointer == PTR_STATUS && !exec |=>
		line_status[ST_LEVEL] == $past(line_sync[1]))
		else $error("line level not sampled at read ack");
	chk_rst_clear_cfg: assert property (exec && cmd_q == CMD_WRITE_CFG |=>
		!line_status[ST_RST] && cfg_wr)
		else $error("config write kept reset flag");
	chk_bad_ptr_nack: assert property (state == S_PARAM && scl_fall && !start_c && !stop_c
		&& bitcnt == BITS_PER_BYTE && cmd_q == CMD_SET_PTR && !param_ok(cmd_q, shreg)
		|=> !sda_oe ##1 read_pointer == $past(read_pointer, 2))
		else $error("invalid pointer code acknowledged");

endmodule

// ### bsr_host_model.sv
/*
 * Host model: a bus master that bit-bangs the two-wire host bus.
 * Assumes the bench resolves the data wire with a pull-up.
 */
`timescale 1ns/1ps
module bsr_host_model (
	input wire logic clock,
	input wire logic sda,
	output logic scl,
	output logic sda_oe,
	output logic rd_valid,
	output logic [7:0] rd_byte
);
	// Clock stands high and data released while idle
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
		rd_valid = 1'b0;
		rd_byte = 8'h00;
	end
	// Quarter of the 160 ns bus period
	task automatic tq();
		repeat (4) @(posedge clock);
	endtask
	// One bit: data moves while clock is low, sampled mid high phase
	task automatic bit_io(input logic b, output logic r);
		tq();
		sda_oe <= ~b;
		tq();
		scl <= 1'b1;
		tq();
		r = sda;
		tq();
		scl <= 1'b0;
	endtask
	// Start or repeated start
	task automatic start();
		tq();
		sda_oe <= 1'b0;
		tq();
		scl <= 1'b1;
		tq();
		sda_oe <= 1'b1;
		tq();
		scl <= 1'b0;
	endtask
	// Stop, leaving the bus idle
	task automatic stop();
		tq();
		sda_oe <= 1'b1;
		tq();
		scl <= 1'b1;
		tq();
		sda_oe <= 1'b0;
		tq();
	endtask
	// Byte out, MSB first; ack is the slave pulling low
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	// Byte in; host acks all but the last byte
	task automatic rbyte(input logic last);
		logic [7:0] d;
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
		rd_byte <= d;
		rd_valid <= 1'b1;
		@(posedge clock);
		rd_valid <= 1'b0;
	endtask
	// Command of one or two bytes in one write transaction
	task automatic command(input logic [6:0] a, input logic [7:0] c, input logic two,
		input logic [7:0] p, output logic [1:0] acks);
		logic x;
		start();
		wbyte({a, 1'b0}, x);
		wbyte(c, acks[1]);
		acks[0] = 1'b0;
		if (two) begin
			wbyte(p, acks[0]);
		end
		stop();
	endtask
	// Read transaction of n bytes
	task automatic read(input logic [6:0] a, input int n, output logic ack);
		start();
		wbyte({a, 1'b1}, ack);
		for (int i = 0; i < n; i++) begin
			rbyte(i == n - 1);
		end
		stop();
	endtask
endmodule

// ### tb.sv
/*
 * Bench for the status and port readback block: host model on the bus,
 * engine results driven by the bench, queue-based read checking.
 * Assumes the design package is compiled first.
 */
`timescale 1ns/1ps
module tb
	import bsr_pkg::*;
;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic line_in = 1'b0;
	logic eng_done = 1'b0;
	logic eng_rst_evt = 1'b0;
	logic eng_presence = 1'b0;
	logic eng_short = 1'b0;
	logic eng_bit_evt = 1'b0;
	logic eng_bit_val = 1'b0;
	bsr_bit_type eng_bit_sel = BIT_FIRST;
	logic [7:0] cfg_value = 8'h00;
	logic [7:0] read_data_value = 8'h00;
	logic sda_out, sda_oe, line_cmd_go, line_abort, cfg_wr, scl, h_oe, rd_valid;
	logic [7:0] line_cmd_code, line_cmd_param, cfg_byte, line_status, read_pointer, rd_byte;
	wire sda = ~(h_oe | sda_oe); // Pull-up: low while anyone drives
	int miscompares = 0;
	int checked = 0;
	int n_go = 0;
	int n_abort = 0;
	int n_cfg = 0;
	logic [7:0] exp_q[$]; // Expected read bytes, oldest first
	logic [7:0] est, seed;
	logic [3:0] c;
	logic [1:0] a;
	logic ak, lv;

	always #5 clock = ~clock;

	bsr_status_port u_bsr_status_port (.clock, .resetn, .scl_in(scl), .sda_in(sda), .sda_out,
		.sda_oe, .line_in, .eng_done, .eng_rst_evt, .eng_presence, .eng_short, .eng_bit_evt,
		.eng_bit_sel, .eng_bit_val, .cfg_value, .read_data_value, .line_cmd_go, .line_cmd_code,
		.line_cmd_param, .line_abort, .cfg_wr, .cfg_byte, .line_status, .read_pointer);
	bsr_host_model u_bsr_host_model (.clock, .sda, .scl, .sda_oe(h_oe), .rd_valid, .rd_byte);

	// Compare and count
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Verdict and end of run
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Watcher: pulse counts and read bytes against the oldest note
	always @(posedge clock) begin
		n_go += (line_cmd_go === 1'b1);
		n_abort += (line_abort === 1'b1);
		n_cfg += (cfg_wr === 1'b1);
		if (rd_valid) begin
			chk("read byte", exp_q.pop_front(), rd_byte);
			chk("sda_out", 8'h00, {7'h0, sda_out});
		end
	end
	// Hang guard, well beyond the expected run
	initial begin
		#400000;
		miscompares++;
		finish_test();
	end
	task automatic cmd(input logic [7:0] cd, input logic two, input logic [7:0] p,
		input logic [1:0] e, input logic [1:0] m);
		u_bsr_host_model.command(u_bsr_status_port.BUS_ADDR, cd, two, p, a);
		chk("ack", {6'h0, e & m}, {6'h0, a & m});
	endtask
	task automatic rd(input int n);
		u_bsr_host_model.read(u_bsr_status_port.BUS_ADDR, n, ak);
		chk("addr ack", 8'h01, {7'h0, ak});
	endtask
	// Status and pointer once settled
	task automatic st(input logic [7:0] p);
		@(negedge clock);
		chk("line_status", est, line_status);
		chk("read_pointer", p, read_pointer);
	endtask
	// One-cycle engine pulse: strobes {done,rst_evt,bit_evt}, v {presence,short}
	task automatic eng(input logic [2:0] s, input logic [1:0] v, input bsr_bit_type sel);
		@(posedge clock);
		{eng_done, eng_rst_evt, eng_bit_evt} <= s;
		{eng_presence, eng_short} <= v;
		eng_bit_val <= v[1];
		eng_bit_sel <= sel;
		@(posedge clock);
		{eng_done, eng_rst_evt, eng_bit_evt} <= 3'h0;
	endtask

	initial begin
		seed = 8'h30;
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		est = STATUS_RESET;
		st(PTR_STATUS);
		@(posedge clock);
		// Two steps so the level differs from reset and the port code from its default
		seed = lfsr(lfsr(seed));
		lv = seed[0];
		line_in <= lv;
		cfg_value <= seed;
		read_data_value <= ~seed;
		exp_q.push_back({est[7:4], lv, est[2:0]});
		exp_q.push_back({est[7:4], lv, est[2:0]});
		rd(2);
		est[ST_LEVEL] = lv;
		@(posedge clock);
		lv = ~lv;
		line_in <= lv;
		st(PTR_STATUS);
		u_bsr_host_model.read(u_bsr_status_port.BUS_ADDR ^ 7'h01, 0, ak);
		chk("foreign addr ack", 8'h00, {7'h0, ak});
		$display("test status read done");
		cmd(u_bsr_status_port.CMD_LINE_RESET, 1'b0, 8'h00, 2'h2, 2'h3);
		est[ST_BUSY] = 1'b1;
		st(PTR_STATUS);
		cmd(CMD_WRITE_CFG, 1'b1, 8'h5a, 2'h0, 2'h3);
		eng(3'h2, 2'h3, BIT_FIRST);
		est[ST_SHORT] = 1'b1;
		st(PTR_STATUS);
		eng(3'h4, 2'h0, BIT_FIRST);
		est[ST_BUSY] = 1'b0;
		st(PTR_STATUS);
		cmd(u_bsr_status_port.CMD_LINE_RESET, 1'b0, 8'h00, 2'h2, 2'h3);
		eng(3'h2, 2'h2, BIT_FIRST);
		eng(3'h4, 2'h0, BIT_FIRST);
		est[ST_SHORT] = 1'b0;
		est[ST_PRES] = 1'b1;
		st(PTR_STATUS);
		$display("test line reset done");
		cmd(u_bsr_status_port.CMD_TRIPLET, 1'b1, 8'h80, 2'h2, 2'h2);
		eng(3'h1, 2'h2, BIT_FIRST);
		eng(3'h1, 2'h2, BIT_SECOND);
		eng(3'h1, 2'h2, BIT_DIR);
		eng(3'h4, 2'h0, BIT_FIRST);
		est[7:5] = 3'h7;
		st(PTR_STATUS);
		cmd(u_bsr_status_port.CMD_SINGLE_BIT, 1'b1, 8'h80, 2'h2, 2'h2);
		eng(3'h1, 2'h0, BIT_FIRST);
		eng(3'h4, 2'h0, BIT_FIRST);
		est[ST_SBR] = 1'b0;
		st(PTR_STATUS);
		// Byte commands must leave the triplet flags alone
		cmd(u_bsr_status_port.CMD_READ_BYTE, 1'b0, 8'h00, 2'h2, 2'h3);
		eng(3'h4, 2'h0, BIT_FIRST);
		cmd(u_bsr_status_port.CMD_WRITE_BYTE, 1'b1, seed, 2'h3, 2'h3);
		eng(3'h4, 2'h0, BIT_FIRST);
		st(PTR_STATUS);
		chk("go count", 8'h06, 8'(n_go));
		chk("line_cmd_code", u_bsr_status_port.CMD_WRITE_BYTE, line_cmd_code);
		chk("line_cmd_param", seed, line_cmd_param);
		$display("test bit results done");
		cmd(CMD_WRITE_CFG, 1'b1, 8'h5a, 2'h3, 2'h3);
		cmd(CMD_WRITE_CFG, 1'b1, 8'h55, 2'h2, 2'h3);
		est[ST_RST] = 1'b0;
		st(PTR_CFG);
		chk("cfg_byte", 8'h5a, cfg_byte);
		chk("cfg count", 8'h01, 8'(n_cfg));
		cmd(CMD_SET_PTR, 1'b1, 8'h12, 2'h2, 2'h3);
		cmd(CMD_SET_PTR, 1'b1, PTR_RDATA, 2'h3, 2'h3);
		exp_q.push_back(read_data_value);
		rd(1);
		cmd(CMD_SET_PTR, 1'b1, PTR_CFG, 2'h3, 2'h3);
		exp_q.push_back({4'h0, cfg_value[3:0]});
		rd(1);
		cmd(CMD_SET_PTR, 1'b1, PTR_STATUS, 2'h3, 2'h3);
		exp_q.push_back({est[7:4], lv, est[2:0]});
		rd(1);
		est[ST_LEVEL] = lv;
		$display("test config and pointer done");
		c = seed[7:4];
		cmd(u_bsr_status_port.CMD_ADJUST_PORT, 1'b1, {4'h0, c}, 2'h3, 2'h3);
		st(PTR_PORT);
		cmd(u_bsr_status_port.CMD_ADJUST_PORT, 1'b1, 8'h83, 2'h3, 2'h3);
		cmd(u_bsr_status_port.CMD_ADJUST_PORT, 1'b1, 8'ha0, 2'h2, 2'h3);
		for (int i = 0; i < 9; i++) begin
			exp_q.push_back((i % 8 == 0) ? {4'h0, c} : ((i == 7) ? 8'h03 : 8'h06));
		end
		rd(9);
		$display("test port readback done");
		cmd(CMD_DEV_RESET, 1'b0, 8'h00, 2'h2, 2'h3);
		est = STATUS_RESET;
		st(PTR_STATUS);
		chk("abort count", 8'h01, 8'(n_abort));
		cmd(CMD_SET_PTR, 1'b1, PTR_PORT, 2'h3, 2'h3);
		exp_q.push_back(8'h06);
		rd(1);
		$display("test device reset done");
		finish_test();
	end
endmodule
